// ---- hw/clock_control.sv ----
// Notes on behaviour
// - After memory demand drops, wait the programmed 0 to 255 cycles, then request memory gating.
// - Bypass bit clear by default: single-rate memory clock is half the double rate.
// - Bypass bit set: single-rate memory clock equals the double-rate clock.
// - Memory source codes: 0 gated, 1 reference clock, 2 memory PLL clock.
// - Serial source codes: 0 gated, 1 reference, 2 system PLL; bits 31..16 reserved.
// - Source acknowledge field reports the source actually in use, same encoding.
// - Divider request asks for division ratio equal to field value plus one.
// - Divider acknowledge reports the ratio in effect, minus one.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module clock_control (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite write address and data.
    input wire logic awvalid,
    output logic awready,
    input wire logic [clock_control_pkg::ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response.
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read.
    input wire logic arvalid,
    output logic arready,
    input wire logic [clock_control_pkg::ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Source clock pins.
    input wire logic reference_clock,
    input wire logic memory_pll_clock,
    input wire logic system_pll_clock,
    // Demand from the clocked logic.
    input wire logic memory_clock_required,
    input wire logic serial_clock_required,
    // Derived clocks and gating requests.
    output logic memory_clock_double_rate,
    output logic memory_clock_single_rate,
    output logic nonsecure_serial_clock,
    output logic memory_gate_request,
    output logic serial_gate_request
);
    import clock_control_pkg::*;

    localparam int NSYNC = 5;

    // Pins cross into this domain through two flops before anything reads them.
    logic [NSYNC-1:0] sync1_reg, sync2_reg;
    logic [NSYNC-1:0] pins;
    assign pins = {serial_clock_required, memory_clock_required,
                   system_pll_clock, memory_pll_clock, reference_clock};

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
        end
    end

    // Register state.
    logic [DELAY_W-1:0] mem_delay_reg, mem_delay_next;
    logic mem_bypass_reg, mem_bypass_next;
    logic [SEL_W-1:0] mem_sel_reg, mem_sel_next;
    logic [DIV_W-1:0] mem_div_reg, mem_div_next;
    // Serial control has no delay field, so its gating request follows demand without a wait.
    localparam logic [DELAY_W-1:0] SER_ENTRY_DELAY = '0;
    logic [SEL_W-1:0] ser_sel_reg, ser_sel_next;
    logic [SEL_W-1:0] mem_sel_ack, ser_sel_ack;
    logic [DIV_W-1:0] mem_div_ack;
    logic mem_double, ser_clock;

    // Bus state.
    logic aw_got_reg, aw_got_next;
    logic w_got_reg, w_got_next;
    logic [ADDR_W-1:0] waddr_reg, waddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic do_write;
    logic [31:0] merged;
    logic [31:0] read_word;
    logic read_hit;
    logic awready_reg, awready_next, wready_reg, wready_next, arready_reg, arready_next;

    function automatic logic [31:0] merge(input logic [31:0] old_word,
                                          input logic [31:0] new_word,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                res[8*i +: 8] = new_word[8*i +: 8];
        merge = res;
    endfunction

    function automatic logic [31:0] reg_word(input logic [ADDR_W-1:0] addr,
                                             input logic [DELAY_W-1:0] md,
                                             input logic mb,
                                             input logic [SEL_W-1:0] ma,
                                             input logic [SEL_W-1:0] ms,
                                             input logic [DIV_W-1:0] mda,
                                             input logic [DIV_W-1:0] mdr,
                                             input logic [SEL_W-1:0] sa,
                                             input logic [SEL_W-1:0] ss);
        logic [31:0] w;
        w = '0;
        case (addr)
            MEM_CTRL_OFFSET:
            begin
                w[DELAY_LSB +: DELAY_W] = md;
                w[BYPASS_BIT] = mb;
                w[SEL_ACK_LSB +: SEL_W] = ma;
                w[SEL_LSB +: SEL_W] = ms;
            end
            MEM_DIV_OFFSET:
            begin
                w[DIV_ACK_LSB +: DIV_W] = mda;
                w[DIV_LSB +: DIV_W] = mdr;
            end
            SER_CTRL_OFFSET:
            begin
                w[SEL_ACK_LSB +: SEL_W] = sa;
                w[SEL_LSB +: SEL_W] = ss;
            end
            default: w = '0;
        endcase
        reg_word = w;
    endfunction

    always_comb
    begin
        aw_got_next = aw_got_reg;
        w_got_next = w_got_reg;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (awvalid && awready)
        begin
            aw_got_next = 1'b1;
            waddr_next = awaddr;
        end
        if (wvalid && wready)
        begin
            w_got_next = 1'b1;
            wdata_next = wdata;
            wstrb_next = wstrb;
        end
        do_write = aw_got_reg && w_got_reg && !bvalid_reg;
        if (do_write)
        begin
            bvalid_next = 1'b1;
            aw_got_next = 1'b0;
            w_got_next = 1'b0;
            bresp_next = ((waddr_reg == MEM_CTRL_OFFSET) || (waddr_reg == MEM_DIV_OFFSET)
                          || (waddr_reg == SER_CTRL_OFFSET)) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bvalid_reg && bready)
            bvalid_next = 1'b0;
        awready_next = !aw_got_next && !bvalid_next;
        wready_next = !w_got_next && !bvalid_next;
    end

    // Only the writable fields are taken from the merged word; acknowledges stay read-only.
    always_comb
    begin
        mem_delay_next = mem_delay_reg;
        mem_bypass_next = mem_bypass_reg;
        mem_sel_next = mem_sel_reg;
        mem_div_next = mem_div_reg;
        ser_sel_next = ser_sel_reg;
        merged = merge(reg_word(waddr_reg, mem_delay_reg, mem_bypass_reg, mem_sel_ack,
                                mem_sel_reg, mem_div_ack, mem_div_reg, ser_sel_ack,
                                ser_sel_reg), wdata_reg, wstrb_reg);
        if (do_write)
        begin
            case (waddr_reg)
                MEM_CTRL_OFFSET:
                begin
                    mem_delay_next = merged[DELAY_LSB +: DELAY_W];
                    mem_bypass_next = merged[BYPASS_BIT];
                    mem_sel_next = merged[SEL_LSB +: SEL_W];
                end
                MEM_DIV_OFFSET: mem_div_next = merged[DIV_LSB +: DIV_W];
                SER_CTRL_OFFSET: ser_sel_next = merged[SEL_LSB +: SEL_W];
                default: mem_div_next = mem_div_reg;
            endcase
        end
    end

    always_comb
    begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        read_word = reg_word(araddr, mem_delay_reg, mem_bypass_reg, mem_sel_ack,
                             mem_sel_reg, mem_div_ack, mem_div_reg, ser_sel_ack,
                             ser_sel_reg);
        read_hit = (araddr == MEM_CTRL_OFFSET) || (araddr == MEM_DIV_OFFSET)
                   || (araddr == SER_CTRL_OFFSET);
        if (arvalid && arready)
        begin
            rvalid_next = 1'b1;
            rdata_next = read_word;
            rresp_next = read_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_reg && rready)
            rvalid_next = 1'b0;
        arready_next = !rvalid_next;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            waddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
            mem_delay_reg <= CTRL_RESET[DELAY_LSB +: DELAY_W];
            mem_bypass_reg <= CTRL_RESET[BYPASS_BIT];
            mem_sel_reg <= CTRL_RESET[SEL_LSB +: SEL_W];
            mem_div_reg <= DIV_RESET[DIV_LSB +: DIV_W];
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            arready_reg <= 1'b1;
            ser_sel_reg <= CTRL_RESET[SEL_LSB +: SEL_W];
        end
        else
        begin
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            mem_delay_reg <= mem_delay_next;
            mem_bypass_reg <= mem_bypass_next;
            mem_sel_reg <= mem_sel_next;
            mem_div_reg <= mem_div_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            arready_reg <= arready_next;
            ser_sel_reg <= ser_sel_next;
        end
    end

    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    clock_source_divider #(.DW(DIV_W)) u_mem_clock (
        .clk(clk),
        .rst_n(rst_n),
        .ref_level(sync2_reg[0]),
        .pll_level(sync2_reg[1]),
        .select_request(mem_sel_reg),
        .divider_request(mem_div_reg),
        .clock_out(mem_double),
        .select_ack(mem_sel_ack),
        .divider_ack(mem_div_ack)
    );

    // The serial clock has no divider here, so its ratio is held at one.
    clock_source_divider #(.DW(1)) u_ser_clock (
        .clk(clk),
        .rst_n(rst_n),
        .ref_level(sync2_reg[0]),
        .pll_level(sync2_reg[2]),
        .select_request(ser_sel_reg),
        .divider_request(1'b0),
        .clock_out(ser_clock),
        .select_ack(ser_sel_ack),
        .divider_ack()
    );

    gate_entry_timer u_mem_gate (
        .clk(clk),
        .rst_n(rst_n),
        .required(sync2_reg[3]),
        .entry_delay(mem_delay_reg),
        .gate_request(memory_gate_request)
    );

    gate_entry_timer u_ser_gate (
        .clk(clk),
        .rst_n(rst_n),
        .required(sync2_reg[4]),
        .entry_delay(SER_ENTRY_DELAY),
        .gate_request(serial_gate_request)
    );

    // Half-rate stage: the output toggles once per rising edge of the double-rate clock.
    logic dbl_prev_reg, half_reg, half_next, single_reg, single_next;
    always_comb
    begin
        half_next = half_reg ^ (mem_double && !dbl_prev_reg);
        single_next = mem_bypass_reg ? mem_double : half_next;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dbl_prev_reg <= 1'b0;
            half_reg <= 1'b0;
            single_reg <= 1'b0;
        end
        else
        begin
            dbl_prev_reg <= mem_double;
            half_reg <= half_next;
            single_reg <= single_next;
        end
    end

    assign memory_clock_double_rate = mem_double;
    assign memory_clock_single_rate = single_reg;
    assign nonsecure_serial_clock = ser_clock;

    a_half_rate: assert property (@(posedge clk) disable iff (!rst_n)
        !mem_bypass_reg && $past(!mem_bypass_reg) && !$past(mem_bypass_reg, 2) && $changed(single_reg)
        |-> $past(mem_double && !dbl_prev_reg))
        else $error("Half-rate clock moved without a double-rate rising edge.");
    a_bypass_follow: assert property (@(posedge clk) disable iff (!rst_n)
        mem_bypass_reg |=> single_reg == $past(mem_double))
        else $error("Bypassed single-rate clock does not follow the double rate.");
    a_sel_ack_read: assert property (@(posedge clk) disable iff (!rst_n)
        arvalid && arready && araddr == MEM_CTRL_OFFSET
        |=> rdata[SEL_ACK_LSB +: SEL_W] == $past(mem_sel_ack))
        else $error("Source acknowledge read back wrong.");
    a_div_ack_read: assert property (@(posedge clk) disable iff (!rst_n)
        arvalid && arready && araddr == MEM_DIV_OFFSET
        |=> rdata[DIV_ACK_LSB +: DIV_W] == $past(mem_div_ack) && rdata[15:5] == '0)
        else $error("Divider acknowledge read back wrong.");
    a_ser_reserved: assert property (@(posedge clk) disable iff (!rst_n)
        arvalid && arready && araddr == SER_CTRL_OFFSET |=> rdata[31:16] == '0)
        else $error("Reserved serial bits read nonzero.");
    a_write_resp: assert property (@(posedge clk) disable iff (!rst_n)
        aw_got_reg && w_got_reg && !bvalid_reg |=> bvalid_reg)
        else $error("Write response missing.");

    c_mem_write: cover property (@(posedge clk) disable iff (!rst_n)
        do_write && waddr_reg == MEM_CTRL_OFFSET);
    c_pll_taken: cover property (@(posedge clk) disable iff (!rst_n)
        mem_sel_ack == SEL_PLL);
    c_gate_req: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(memory_gate_request));
    c_bypass_on: cover property (@(posedge clk) disable iff (!rst_n)
        mem_bypass_reg && $changed(single_reg));
endmodule
`default_nettype wire

// ---- hw/clock_source_divider.sv ----
`timescale 1ns/1ps
`default_nettype none
module clock_source_divider #(
    parameter int DW = 5
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Synchronised source levels.
    input wire logic ref_level,
    input wire logic pll_level,
    // Requests from software.
    input wire logic [clock_control_pkg::SEL_W-1:0] select_request,
    input wire logic [DW-1:0] divider_request,
    // Derived clock and acknowledges.
    output logic clock_out,
    output logic [clock_control_pkg::SEL_W-1:0] select_ack,
    output logic [DW-1:0] divider_ack
);
    import clock_control_pkg::*;

    logic [SEL_W-1:0] sel_reg, sel_next;
    logic [DW-1:0] div_reg, div_next;
    logic [DW-1:0] count_reg, count_next;
    logic out_reg, out_next;
    logic ref_prev_reg, pll_prev_reg;
    logic src_edge;
    logic last_edge;
    logic boundary;

    // Both edges of the source are counted, so N edges per half period divide by N.
    always_comb
    begin
        src_edge = source_level(sel_reg, ref_level, pll_level)
                   ^ source_level(sel_reg, ref_prev_reg, pll_prev_reg);
        last_edge = src_edge && (count_reg == div_reg);
        sel_next = sel_reg;
        div_next = div_reg;
        count_next = count_reg;
        out_next = out_reg;
        if (src_edge)
        begin
            count_next = last_edge ? '0 : count_reg + 1'b1;
            out_next = last_edge ? ~out_reg : out_reg;
        end
        // Changes land only at the start of a low phase, so no runt pulse appears.
        boundary = (sel_reg == SEL_GATED) || (last_edge && out_reg);
        if (boundary && ((select_request != sel_reg) || (divider_request != div_reg)))
        begin
            // Reserved codes are parked on the gated state rather than guessed at.
            sel_next = valid_code(select_request) ? select_request : SEL_GATED;
            div_next = divider_request;
            count_next = '0;
            out_next = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_reg <= SEL_GATED;
            div_reg <= '0;
            count_reg <= '0;
            out_reg <= 1'b0;
            ref_prev_reg <= 1'b0;
            pll_prev_reg <= 1'b0;
        end
        else
        begin
            sel_reg <= sel_next;
            div_reg <= div_next;
            count_reg <= count_next;
            out_reg <= out_next;
            ref_prev_reg <= ref_level;
            pll_prev_reg <= pll_level;
        end
    end

    assign clock_out = out_reg;
    assign select_ack = sel_reg;
    assign divider_ack = div_reg;

    a_ack_at_low: assert property (@(posedge clk) disable iff (!rst_n)
        ($changed(sel_reg) || $changed(div_reg)) |-> !out_reg)
        else $error("Acknowledge changed while the clock was high.");
    a_gated_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (sel_reg == SEL_GATED) |-> !out_reg ##1 (sel_reg != SEL_GATED || !out_reg))
        else $error("Gated clock toggled.");
    a_count_bound: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(out_reg) && $past(sel_reg) == sel_reg |-> $past(count_reg) == $past(div_reg))
        else $error("Clock toggled before the divider count elapsed.");
endmodule
`default_nettype wire

// ---- hw/gate_entry_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module gate_entry_timer (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Demand and delay.
    input wire logic required,
    input wire logic [clock_control_pkg::DELAY_W-1:0] entry_delay,
    // Gating request.
    output logic gate_request
);
    import clock_control_pkg::*;

    typedef enum logic [1:0] {RUNNING, WAITING, GATED} gate_state_t;
    gate_state_t state_reg, state_next;
    logic [DELAY_W-1:0] count_reg, count_next;
    logic gate_reg, gate_next;

    always_comb
    begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            RUNNING:
            begin
                if (!required)
                begin
                    state_next = (entry_delay == '0) ? GATED : WAITING;
                    count_next = {{(DELAY_W-1){1'b0}}, 1'b1};
                end
            end
            WAITING:
            begin
                if (required)
                    state_next = RUNNING;
                else if (count_reg >= entry_delay)
                    state_next = GATED;
                else
                    count_next = count_reg + 1'b1;
            end
            GATED:
            begin
                if (required)
                    state_next = RUNNING;
            end
            default: state_next = RUNNING;
        endcase
        gate_next = (state_next == GATED);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= RUNNING;
            count_reg <= '0;
            gate_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            count_reg <= count_next;
            gate_reg <= gate_next;
        end
    end

    assign gate_request = gate_reg;

    a_entry_wait: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == WAITING && !required && count_reg < entry_delay |=> !gate_request)
        else $error("Gating requested before the entry delay elapsed.");
    a_entry_due: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == WAITING && !required && count_reg >= entry_delay |=> gate_request)
        else $error("Gating not requested when the entry delay elapsed.");
endmodule
`default_nettype wire

// ---- include/clock_control_pkg.sv ----
`default_nettype none
package clock_control_pkg;
    localparam int ADDR_W = 12;
    localparam int SEL_W = 8;
    localparam int DIV_W = 5;
    localparam int DELAY_W = 8;
    localparam logic [ADDR_W-1:0] MEM_CTRL_OFFSET = 12'h880;
    localparam logic [ADDR_W-1:0] MEM_DIV_OFFSET = 12'h884;
    localparam logic [ADDR_W-1:0] SER_CTRL_OFFSET = 12'h8A0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [31:0] DIV_RESET = 32'h0000_001F;
    localparam int DELAY_LSB = 24;
    localparam int BYPASS_BIT = 16;
    localparam int SEL_ACK_LSB = 8;
    localparam int SEL_LSB = 0;
    localparam int DIV_ACK_LSB = 16;
    localparam int DIV_LSB = 0;
    localparam logic [SEL_W-1:0] SEL_GATED = 8'h00;
    localparam logic [SEL_W-1:0] SEL_REF = 8'h01;
    localparam logic [SEL_W-1:0] SEL_PLL = 8'h02;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic source_level(input logic [SEL_W-1:0] code,
                                          input logic ref_lvl,
                                          input logic pll_lvl);
        source_level = (code == SEL_REF) ? ref_lvl : (code == SEL_PLL) ? pll_lvl : 1'b0;
    endfunction

    function automatic logic valid_code(input logic [SEL_W-1:0] code);
        valid_code = (code == SEL_GATED) || (code == SEL_REF) || (code == SEL_PLL);
    endfunction
endpackage
`default_nettype wire

// ---- sim/tb_clock_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_clock_control;
    import clock_control_pkg::*;
    logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata, rnd = 32'h1988;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp;
    logic reference_clock = 0, memory_pll_clock = 0, system_pll_clock = 0;
    logic memory_clock_required = 1, serial_clock_required = 1;
    logic awready, wready, bvalid, arready, rvalid, memory_clock_double_rate;
    logic memory_clock_single_rate, nonsecure_serial_clock, memory_gate_request, serial_gate_request;
    logic [33:0] notes[$];
    int fails = 0, comparisons = 0, cd = 0, cs = 0, cn = 0;
    clock_control dut (.clk(clk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .reference_clock(reference_clock), .memory_pll_clock(memory_pll_clock),
        .system_pll_clock(system_pll_clock), .memory_clock_required(memory_clock_required),
        .serial_clock_required(serial_clock_required), .memory_clock_double_rate(memory_clock_double_rate),
        .memory_clock_single_rate(memory_clock_single_rate), .nonsecure_serial_clock(nonsecure_serial_clock),
        .memory_gate_request(memory_gate_request), .serial_gate_request(serial_gate_request));
    // Source clocks stay well below half the system clock, as the synchronisers need.
    always #4 clk = ~clk;
    always #40 reference_clock = ~reference_clock;
    always #28 memory_pll_clock = ~memory_pll_clock;
    always #36 system_pll_clock = ~system_pll_clock;
    always @(posedge memory_clock_double_rate) cd++;
    always @(posedge memory_clock_single_rate) cs++;
    always @(posedge nonsecure_serial_clock) cn++;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp_word(input logic [33:0] got, input logic [33:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic ok);
        #1;
        comparisons++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("Error at %0t: output level or count wrong", $time);
        end
    endtask
    // Ready is driven straight from a register, so its value at the falling edge holds at the next rise.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        logic ad, wd;
        notes.push_back({r, 32'h0});
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && wd))
        begin
            @(negedge clk);
            ad |= awready;
            wd |= wready;
            @(posedge clk);
            if (ad) awvalid <= 1'b0;
            if (wd) wvalid <= 1'b0;
        end
        bready <= 1'b1;
        do begin @(negedge clk); ad = bvalid; @(posedge clk); end while (!ad);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ok;
        notes.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        do begin @(negedge clk); ok = arready; @(posedge clk); end while (!ok);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do begin @(negedge clk); ok = rvalid; @(posedge clk); end while (!ok);
        rready <= 1'b0;
    endtask
    always @(posedge clk)
    begin
        if (rvalid && rready)
            cmp_word({rresp, rdata}, notes.pop_front());
        if (bvalid && bready)
            cmp_word({bresp, 32'h0}, notes.pop_front());
    end
    task automatic ratio(input logic byp);
        wr(MEM_CTRL_OFFSET, {15'h0, byp, 16'h0002});
        repeat (100) @(posedge clk);
        cd = 0;
        cs = 0;
        cn = 0;
        repeat (3000) @(posedge clk);
        cmp_bit(cn inside {[332:335]});
        cmp_bit(cd inside {[427:430]});
        cmp_bit(byp ? (cd - cs) inside {[-1:1]} : (cd - 2 * cs) inside {[-2:2]});
    endtask
    task automatic gate(input logic [7:0] d);
        wr(MEM_CTRL_OFFSET, {d, 24'h000002});
        memory_clock_required <= 1'b0;
        serial_clock_required <= 1'b0;
        repeat (d + 2) @(posedge clk);
        cmp_bit(memory_gate_request === 1'b0);
        repeat (4) @(posedge clk);
        cmp_bit(memory_gate_request === 1'b1 && serial_gate_request === 1'b1);
        memory_clock_required <= 1'b1;
        serial_clock_required <= 1'b1;
        repeat (6) @(posedge clk);
        cmp_bit(memory_gate_request === 1'b0 && serial_gate_request === 1'b0);
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d, fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // The whole sequence needs about 13000 cycles, so this leaves ample margin.
    initial
    begin
        #(60000 * 8);
        fails++;
        print_verdict();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(MEM_CTRL_OFFSET, CTRL_RESET | 32'h0000_0100, RESP_OKAY);
        rd(MEM_DIV_OFFSET, 32'h001F_001F, RESP_OKAY);
        rd(SER_CTRL_OFFSET, 32'h0000_0101, RESP_OKAY);
        wr(12'h888, 32'hFFFF_FFFF, RESP_SLVERR);
        rd(12'h888, 32'h0, RESP_SLVERR);
        for (int i = 0; i < 4; i++)
        begin
            rnd = lfsr(rnd);
            wr(MEM_DIV_OFFSET, rnd);
            repeat (800) @(posedge clk);
            rd(MEM_DIV_OFFSET, {11'h0, rnd[4:0], 11'h0, rnd[4:0]}, RESP_OKAY);
        end
        for (int s = 0; s < 3; s++)
        begin
            wr(MEM_CTRL_OFFSET, {24'h0, s[7:0]});
            wr(SER_CTRL_OFFSET, {24'h0, s[7:0]});
            repeat (800) @(posedge clk);
            rd(MEM_CTRL_OFFSET, {16'h0, s[7:0], s[7:0]}, RESP_OKAY);
            rd(SER_CTRL_OFFSET, {16'h0, s[7:0], s[7:0]}, RESP_OKAY);
        end
        wr(MEM_DIV_OFFSET, 32'h0);
        repeat (800) @(posedge clk);
        ratio(1'b0);
        ratio(1'b1);
        rd(MEM_CTRL_OFFSET, 32'h0001_0202, RESP_OKAY);
        gate(8'h00);
        gate(8'hFF);
        print_verdict();
    end
endmodule
`default_nettype wire
